/* File: bench/mscan_assertions.sv */
`timescale 1ns/1ps
module mscan_assertions
    import mscan_pkg::*;
#(
    parameter int AW = 16
) (
    input wire logic          clock,     // System clock.
    input wire logic          rst,       // System reset.
    input wire mscan_req_t    cpu_req,   // CPU request.
    input wire logic [7:0]    cpu_rdata, // CPU read data.
    input wire mscan_dbg_t    dbg,       // Debugger events.
    input wire logic [1:0]    dbg_st_r,  // Status copy.
    input wire logic [AW-1:0] fl_addr_r, // Flash address.
    input wire logic          fl_rd_r,   // Flash request.
    input wire logic          nmi_r      // Interrupt.
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    property p_rdz; !$past(cpu_req.rd) |-> cpu_rdata == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("stray read data");
    property p_hi;
        $past(cpu_req.rd && cpu_req.addr != MSCAN_OFS_SETUP)
            |-> cpu_rdata[7:2] == 6'h00;
    endproperty
    a_hi: assert property (p_hi) else $error("unused bits set");
    property p_stick; nmi_r |=> nmi_r; endproperty
    a_stick: assert property (p_stick) else $error("nmi dropped");
    property p_nmi_ok; $rose(nmi_r) |=> !dbg_st_r[1]; endproperty
    a_nmi_ok: assert property (p_nmi_ok) else $error("nmi, ok set");
    property p_dbg; dbg.acc |-> ##2 !fl_rd_r[*8]; endproperty
    a_dbg: assert property (p_dbg) else $error("read while held");
    property p_start;
        cpu_req.wr && cpu_req.addr == MSCAN_OFS_CTRL && cpu_req.wdata[0]
            && !dbg_st_r[0] && !nmi_r |=> !fl_rd_r[*3] ##[1:4] fl_rd_r;
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_first; $rose(fl_rd_r) |-> fl_addr_r == '0; endproperty
    a_first: assert property (p_first) else $error("not byte 0");
    property p_step;
        fl_rd_r && $past(fl_rd_r) |-> fl_addr_r == $past(fl_addr_r) + 1'b1;
    endproperty
    a_step: assert property (p_step) else $error("address skip");
    c_nmi: cover property ($rose(nmi_r));
    c_hold: cover property (dbg.acc && dbg_st_r[0]);
    c_read: cover property (fl_rd_r);
endmodule : mscan_assertions

bind mscan_top mscan_assertions #(.AW(AW)) u_mscan_assertions (
    .clock(clock), .rst(rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .dbg(dbg), .dbg_st_r(dbg_st_r), .fl_addr_r(fl_addr_r),
    .fl_rd_r(fl_rd_r), .nmi_r(nmi_r));

/* File: bench/mscan_flash_model.sv */
`timescale 1ns/1ps
module mscan_flash_model #(
    parameter int AW = 16
) (
    input  wire logic          clock, // System clock.
    input  wire logic [AW-1:0] addr,  // Byte address.
    input  wire logic          rd,    // Byte request.
    output logic [7:0]         data   // Byte, one cycle later.
);
    logic [7:0] mem [2**AW];
    // Between reads the bus changes every cycle, never holding the last byte.
    initial data = 8'h5A;
    always @(posedge clock) begin
        data <= rd ? mem[addr] : ~data;
    end
endmodule : mscan_flash_model

/* File: bench/tb_mscan_top.sv */
`timescale 1ns/1ps
module tb_mscan_top
    import mscan_pkg::*;
;
    localparam int AW = 8;
    localparam int LAST = 63;
    logic          clock, rst, dbg_st_rd, boot_scan, fl_rd_r, cpu_halt_r;
    logic          nmi_r;
    logic [1:0]    boot_sect, dbg_st_r, sect_sel_r;
    logic [7:0]    cpu_rdata, fl_data, v;
    logic [AW-1:0] fl_addr_r;
    mscan_req_t    req;
    mscan_dbg_t    dbg;
    int            checks = 0;
    int            n_mismatch = 0;
    mscan_top #(.AW(AW)) u_mscan_top (.clock(clock), .rst(rst), .cpu_req(req),
        .cpu_rdata(cpu_rdata), .dbg(dbg), .dbg_st_rd(dbg_st_rd),
        .dbg_st_r(dbg_st_r), .boot_scan(boot_scan), .boot_sect(boot_sect),
        .sect_last(8'(LAST)), .sect_sel_r(sect_sel_r), .fl_addr_r(fl_addr_r),
        .fl_rd_r(fl_rd_r), .fl_data(fl_data), .cpu_halt_r(cpu_halt_r),
        .nmi_r(nmi_r));
    mscan_flash_model #(.AW(AW)) u_mscan_flash_model (.clock(clock),
        .addr(fl_addr_r), .rd(fl_rd_r), .data(fl_data));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic finish_test();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
        for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? MSCAN_CRC_POLY : 16'h0000);
        return c;
    endfunction : crc_upd
    // Checksum sits big-endian in the last two bytes; a bad image flips one.
    task automatic fill(input logic good);
        logic [15:0] c;
        c = MSCAN_CRC_INIT;
        for (int i = 0; i < LAST - 1; i++) begin
            u_mscan_flash_model.mem[i] = 8'($urandom);
            c = crc_upd(c, u_mscan_flash_model.mem[i]);
        end
        u_mscan_flash_model.mem[LAST-1] = c[15:8];
        u_mscan_flash_model.mem[LAST] = c[7:0] ^ {7'h00, !good};
    endtask : fill
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clock);
        req <= '0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [1:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hFF);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock);
        req <= '0;
        #1 cmp(cpu_rdata & m, e);
        @(posedge clock);
    endtask : rd
    task automatic dbgp(input logic [12:0] x);
        {dbg_st_rd, dbg} <= x;
        @(posedge clock);
        {dbg_st_rd, dbg} <= '0;
        @(posedge clock);
    endtask : dbgp
    task automatic wait_idle();
        int n;
        n = 0;
        repeat (4) @(posedge clock);
        while (dbg_st_r[0] !== 1'b0 && n < 999) begin
            @(posedge clock);
            n++;
        end
        if (n == 999) n_mismatch++;
    endtask : wait_idle
    task automatic sysreset();
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask : sysreset
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h13349E98));
        {req, dbg, dbg_st_rd, boot_scan, boot_sect} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h02);
        wr(2'h3, 8'hFF);
        rd(2'h0, 8'h00);
        v = 8'($urandom);
        wr(2'h1, v);
        rd(2'h1, v & 8'h33);
        for (int s = 0; s < 3; s++) begin
            fill(1'b1);
            wr(2'h1, 8'(s));
            wr(2'h0, 8'h01);
            rd(2'h2, 8'h01, 8'h01);
            wr(2'h1, 8'(s) ^ 8'h03);
            cmp(8'(cpu_halt_r), 8'h01);
            wait_idle();
            rd(2'h2, 8'h02);
            rd(2'h1, 8'(s));
            cmp(8'(sect_sel_r), 8'(s));
        end
        wr(2'h0, 8'h00);
        rd(2'h0, 8'h01);
        fill(1'b0);
        wr(2'h0, 8'h01);
        wait_idle();
        rd(2'h2, 8'h00);
        cmp(8'(nmi_r), 8'h00);
        dbgp(13'h0102);
        rd(2'h2, 8'h02);
        fill(1'b1);
        wr(2'h0, 8'h01);
        repeat (9) @(posedge clock);
        dbgp(13'h0800);
        repeat (30) @(posedge clock);
        rd(2'h2, 8'h01, 8'h01);
        dbgp(13'h0400);
        wait_idle();
        rd(2'h2, 8'h02);
        cmp(8'(dbg_st_r), 8'h02);
        wr(2'h0, 8'h01);
        repeat (9) @(posedge clock);
        dbgp(13'h0800);
        dbgp(13'h0102);
        dbgp(13'h1000);
        repeat (9) @(posedge clock);
        rd(2'h2, 8'h00, 8'h01);
        dbgp(13'h0800);
        dbgp(13'h0103);
        repeat (9) @(posedge clock);
        rd(2'h2, 8'h01, 8'h01);
        dbgp(13'h0200);
        wait_idle();
        rd(2'h2, 8'h02);
        wr(2'h0, 8'h01);
        repeat (6) @(posedge clock);
        wr(2'h0, 8'h80);
        rd(2'h0, 8'h00);
        rd(2'h1, 8'h00);
        rd(2'h2, 8'h00);
        wr(2'h0, 8'h02);
        rd(2'h0, 8'h02);
        wr(2'h0, 8'h01);
        repeat (6) @(posedge clock);
        wr(2'h0, 8'h80);
        rd(2'h2, 8'h01, 8'h01);
        wait_idle();
        wr(2'h0, 8'h80);
        rd(2'h0, 8'h02);
        wr(2'h1, 8'h01);
        fill(1'b0);
        wr(2'h0, 8'h01);
        wait_idle();
        cmp(8'(nmi_r), 8'h01);
        wr(2'h1, 8'h02);
        rd(2'h1, 8'h01);
        sysreset();
        cmp(8'(nmi_r), 8'h00);
        wr(2'h0, 8'h02);
        dbgp(13'h0100);
        @(posedge clock);
        cmp(8'(nmi_r), 8'h01);
        sysreset();
        fill(1'b1);
        boot_sect <= 2'h1;
        boot_scan <= 1'b1;
        @(posedge clock);
        boot_scan <= 1'b0;
        wait_idle();
        rd(2'h0, 8'h01);
        rd(2'h1, 8'h11);
        wr(2'h1, 8'h01);
        rd(2'h1, 8'h01);
        finish_test();
    end
endmodule : tb_mscan_top

/* File: verilog/mscan_pkg.sv */
package mscan_pkg;

    localparam logic [1:0] MSCAN_OFS_CTRL   = 2'h0;
    localparam logic [1:0] MSCAN_OFS_SETUP  = 2'h1;
    localparam logic [1:0] MSCAN_OFS_STATUS = 2'h2;

    localparam int MSCAN_BIT_ENABLE   = 0;
    localparam int MSCAN_BIT_FAIL_INTERRUPT_ENABLE    = 1;
    localparam int MSCAN_BIT_SRESET   = 7;
    localparam int MSCAN_BIT_BUSY     = 0;
    localparam int MSCAN_BIT_OK       = 1;
    localparam int MSCAN_LSB_MODE     = 4;
    localparam int MSCAN_LSB_SECT     = 0;

    localparam logic [7:0] MSCAN_RST_CTRL   = 8'h00;
    localparam logic [7:0] MSCAN_RST_SETUP  = 8'h00;
    localparam logic [7:0] MSCAN_RST_STATUS = 8'h02;

    localparam logic [1:0] MSCAN_SECT_FLASH = 2'h0;
    localparam logic [1:0] MSCAN_SECT_BAPP  = 2'h1;
    localparam logic [1:0] MSCAN_SECT_BOOT  = 2'h2;
    localparam logic [1:0] MSCAN_MODE_PRIO  = 2'h0;

    localparam logic [15:0] MSCAN_CRC_POLY = 16'h1021;
    localparam logic [15:0] MSCAN_CRC_INIT = 16'hFFFF;

    localparam logic [1:0] MSCAN_START_DLY = 2'h3;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } mscan_req_t;

    typedef struct packed {
        logic acc;
        logic reg_acc;
        logic disc;
        logic wr_status;
        logic [7:0] wdata;
    } mscan_dbg_t;

    typedef enum logic [1:0] {
        MSCAN_IDLE,
        MSCAN_WAIT,
        MSCAN_RUN
    } mscan_state_t;

endpackage : mscan_pkg

/* File: verilog/mscan_top.sv */
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps

// Functional notes
// - Debugger memory or peripheral access disables the checker meanwhile.
// - Interrupted scan restarts from start on debug register access.
// - Busy stays 1 while held off, but no bytes are processed.
// - Debugger status copy readable without disabling; reading re-enables.
// - Debugger writing busy 0 cancels the pending or running scan.
// - Debugger writing busy 1 schedules one scan, starts when released.
// - Setup write ignored while busy or after NMI; enable-bit too.
// - Debugger clearing pass raises NMI if enabled; NMI blocks writes.
// - Debugger writing pass 1 makes it read 1 when not busy.
// - Debugger writes reach only the status register; control writes come from the CPU.
// - Self-reset strobe clears setup, status and enable one cycle later, not interrupt enable.
// - Strobe always acts with NMI disabled, else only when idle.
// - Failure raises NMI when enabled; only system reset clears interrupt enable.
// - Setting the interrupt enable only works while not busy.
// - Writing enable 1 starts a scan; bit stays 1; 0 ignored.
// - Mode field bits 5:4, value 0 is priority scan halting CPU.
// - Section field bits 1:0 selects whole, boot+app or boot.
// - Start-up scan leaves section and enable bits showing that scan.
// - Pass flag reads 1 after reset and reports the last scan.
// - Busy flag reads 1 for the whole scan.
// - Checksum uses CCITT polynomial preset to all ones.
// - Bytes fed from byte 0 upward, most significant bit first.
// - Scan begins three cycles after enable is written.
// - Failure clears pass; raised NMI stays until system reset.
module mscan_top
    import mscan_pkg::*;
#(
    parameter int AW = 16
) (
    input  wire logic          clock,        // System clock.
    input  wire logic          rst,          // System reset.
    input  wire mscan_req_t    cpu_req,      // CPU register request.
    output logic [7:0]         cpu_rdata,    // CPU read data.
    input  wire mscan_dbg_t    dbg,          // Debugger events and writes.
    input  wire logic          dbg_st_rd,    // Debugger status copy read.
    output logic [1:0]         dbg_st_r,     // Synchronized status copy.
    input  wire logic          boot_scan,    // Start-up scan request pulse.
    input  wire logic [1:0]    boot_sect,    // Start-up scan section.
    input  wire logic [AW-1:0] sect_last,    // Last address of selection.
    output logic [1:0]         sect_sel_r,   // Section to scan.
    output logic [AW-1:0]      fl_addr_r,    // Flash byte address.
    output logic               fl_rd_r,      // Flash byte request.
    input  wire logic [7:0]    fl_data,      // Flash byte, next cycle.
    output logic               cpu_halt_r,   // Priority scan stalls CPU.
    output logic               nmi_r         // Non-maskable interrupt.
);

    mscan_state_t    st_r;
    logic [1:0]      dly_r;
    logic            en_r;
    logic            fail_interrupt_enable_r;
    logic            sreset_r;
    logic [1:0]      mode_r;
    logic            busy_r;
    logic            ok_r;
    logic            hold_r;
    logic [15:0]     crc_r;
    logic [AW-1:0]   addr_r;
    logic            vld_r;
    logic            last_r;
    logic            wr;
    logic [1:0]      wa;
    logic [7:0]      wd;
    logic            idle_ok;
    logic            start_req;
    logic            crc_pass;
    logic [15:0]     crc_nxt;
    logic            ctrl_wr;
    logic            setup_wr;
    logic            dbg_cancel;
    logic            dbg_sched;
    logic            scan_kill;
    logic            scan_start;
    logic            scan_done;

    function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                             input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? MSCAN_CRC_POLY : 16'h0);
        end
        return r;
    endfunction : crc_byte

    // Register write decode for enable and setup; interrupt enable and self-reset decode inline.
    function automatic logic wr_hit(input logic       w,
                                    input logic [1:0] a,
                                    input logic [1:0] ofs);
        return w && (a == ofs);
    endfunction : wr_hit

    // Read-back image of one register; unused bits read zero.
    function automatic logic [7:0] rd_image(input logic [1:0] a,
                                            input logic       en,
                                            input logic       fail_interrupt_enable,
                                            input logic [1:0] mode,
                                            input logic [1:0] sect,
                                            input logic       ok,
                                            input logic       busy);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            MSCAN_OFS_CTRL:   r = {6'h00, fail_interrupt_enable, en};
            MSCAN_OFS_SETUP:  r = {2'h0, mode, 2'h0, sect};
            MSCAN_OFS_STATUS: r = {6'h00, ok, busy};
            default:          r = 8'h00;
        endcase
        return r;
    endfunction : rd_image

    // Only CPU writes take the control path; the debugger term is masked off.
    assign wr = (cpu_req.wr | (dbg.wr_status & 1'b0)) & ~nmi_r;
    assign wa = cpu_req.addr;
    assign wd = cpu_req.wdata;
    assign idle_ok = ~busy_r;
    assign ctrl_wr = wr_hit(wr, wa, MSCAN_OFS_CTRL);
    assign setup_wr = wr_hit(wr, wa, MSCAN_OFS_SETUP);
    assign start_req = ctrl_wr && wd[MSCAN_BIT_ENABLE] && !sreset_r;
    // Debugger status writes are refused once the interrupt has fired.
    assign dbg_cancel = dbg.wr_status && !nmi_r
                        && !dbg.wdata[MSCAN_BIT_BUSY];
    assign dbg_sched = dbg.wr_status && !nmi_r
                       && dbg.wdata[MSCAN_BIT_BUSY];
    assign scan_kill = sreset_r || dbg_cancel;
    assign scan_start = start_req || boot_scan || dbg_sched;
    assign scan_done = st_r == MSCAN_RUN && last_r && vld_r && !hold_r;
    assign crc_nxt = vld_r ? crc_byte(crc_r, fl_data) : crc_r;
    assign crc_pass = (crc_nxt == 16'h0000);

    // Debugger hold-off of the checker.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hold_r <= 1'b0;
        end else if (dbg.reg_acc || dbg.disc || dbg_st_rd) begin
            hold_r <= 1'b0;
        end else if (dbg.acc) begin
            hold_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dbg_st_r <= 2'h0;
        end else begin
            dbg_st_r <= {ok_r, busy_r};
        end
    end

    // Self-reset strobe, acted on the cycle after the write.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sreset_r <= 1'b0;
        end else begin
            sreset_r <= wr && wa == MSCAN_OFS_CTRL && wd[MSCAN_BIT_SRESET]
                        && (!fail_interrupt_enable_r || idle_ok);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fail_interrupt_enable_r <= 1'b0;
        end else if (wr && wa == MSCAN_OFS_CTRL && wd[MSCAN_BIT_FAIL_INTERRUPT_ENABLE]
                     && idle_ok) begin
            fail_interrupt_enable_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            en_r <= 1'b0;
        end else if (sreset_r) begin
            en_r <= 1'b0;
        end else if (start_req || boot_scan) begin
            en_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sect_sel_r <= MSCAN_RST_SETUP[1:0];
        end else if (sreset_r) begin
            sect_sel_r <= MSCAN_RST_SETUP[1:0];
        end else if (boot_scan) begin
            sect_sel_r <= boot_sect;
        end else if (setup_wr && idle_ok) begin
            sect_sel_r <= wd[1:0];
        end
    end

    // A start-up scan leaves a non-zero mode behind; software rewrites it.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mode_r <= MSCAN_RST_SETUP[5:4];
        end else if (sreset_r) begin
            mode_r <= MSCAN_RST_SETUP[5:4];
        end else if (boot_scan) begin
            mode_r <= 2'h1;
        end else if (setup_wr && idle_ok) begin
            mode_r <= wd[5:4];
        end
    end

    // Scan sequencer: wait three cycles, then stream bytes.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= MSCAN_IDLE;
        end else if (scan_kill) begin
            st_r <= MSCAN_IDLE;
        end else begin
            case (st_r)
                MSCAN_IDLE: begin
                    if (scan_start) begin
                        st_r <= MSCAN_WAIT;
                    end
                end
                MSCAN_WAIT: begin
                    if (!hold_r && dly_r == 2'h0) begin
                        st_r <= MSCAN_RUN;
                    end
                end
                MSCAN_RUN: begin
                    if (hold_r) begin
                        st_r <= MSCAN_WAIT;
                    end else if (last_r && vld_r) begin
                        st_r <= MSCAN_IDLE;
                    end
                end
                default: st_r <= MSCAN_IDLE;
            endcase
        end
    end

    // Start delay; a scan held off while running resumes with no further delay.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dly_r <= 2'h0;
        end else if (st_r == MSCAN_IDLE && scan_start) begin
            dly_r <= MSCAN_START_DLY - 2'h1;
        end else if (st_r == MSCAN_RUN && hold_r) begin
            dly_r <= 2'h0;
        end else if (st_r == MSCAN_WAIT && !hold_r && dly_r != 2'h0) begin
            dly_r <= dly_r - 2'h1;
        end
    end

    // Busy stays set while the debugger holds the scan off.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
        end else if (scan_kill) begin
            busy_r <= 1'b0;
        end else if (st_r == MSCAN_IDLE && scan_start) begin
            busy_r <= 1'b1;
        end else if (scan_done) begin
            busy_r <= 1'b0;
        end
    end

    // Every entry to the wait state rewinds the scan to byte 0.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_r <= '0;
        end else if (st_r == MSCAN_WAIT) begin
            addr_r <= '0;
        end else if (st_r == MSCAN_RUN && !hold_r && !last_r) begin
            addr_r <= addr_r + AW'(1);
        end
    end

    // Flash returns each byte in the cycle after its request.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fl_rd_r <= 1'b0;
        end else begin
            fl_rd_r <= st_r == MSCAN_RUN && !hold_r && !last_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fl_addr_r <= '0;
        end else begin
            fl_addr_r <= addr_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            vld_r <= 1'b0;
        end else begin
            vld_r <= fl_rd_r;
        end
    end

    // Marks the byte holding the low half of the stored checksum.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            last_r <= 1'b0;
        end else begin
            last_r <= st_r == MSCAN_RUN && fl_rd_r && fl_addr_r == sect_last;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            crc_r <= MSCAN_CRC_INIT;
        end else if (st_r != MSCAN_RUN) begin
            crc_r <= MSCAN_CRC_INIT;
        end else begin
            crc_r <= crc_nxt;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ok_r <= MSCAN_RST_STATUS[MSCAN_BIT_OK];
        end else if (st_r == MSCAN_RUN && last_r && vld_r && !hold_r) begin
            ok_r <= crc_pass;
        end else if (sreset_r) begin
            ok_r <= 1'b0;
        end else if (dbg.wr_status && !nmi_r) begin
            ok_r <= dbg.wdata[MSCAN_BIT_OK];
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nmi_r <= 1'b0;
        end else if (fail_interrupt_enable_r && ((st_r == MSCAN_RUN && last_r && vld_r
                     && !hold_r && !crc_pass) || (dbg.wr_status
                     && !dbg.wdata[MSCAN_BIT_OK]))) begin
            nmi_r <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_halt_r <= 1'b0;
        end else begin
            cpu_halt_r <= busy_r && st_r != MSCAN_WAIT
                          && mode_r == MSCAN_MODE_PRIO;
        end
    end

    // Read port; strobe bit and unused bits read zero.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_rdata <= 8'h00;
        end else if (cpu_req.rd) begin
            cpu_rdata <= rd_image(cpu_req.addr, en_r, fail_interrupt_enable_r, mode_r,
                                  sect_sel_r, ok_r, busy_r);
        end else begin
            cpu_rdata <= 8'h00;
        end
    end

endmodule : mscan_top
